/* File: include/rassw_pkg.sv */
`default_nettype none
package rassw_pkg;
   // Link timing
   localparam int unsigned CLK_HZ         = 250_000_000;
   localparam int unsigned BAUD_HZ        = 9600;
   localparam int unsigned BIT_CYC        = CLK_HZ / BAUD_HZ;
   localparam int unsigned HALF_CYC       = BIT_CYC / 2;
   localparam int unsigned DATA_BITS      = 8;
   localparam int unsigned STOP_BITS      = 1;
   localparam int unsigned CNT_W          = 16;
   // Command characters
   localparam logic [7:0]  CHR_FLOW_OFF   = 8'h13;
   localparam logic [7:0]  CHR_SOH        = 8'h01;
   // Reset values
   localparam logic [7:0]  ADDR_DEFAULT   = 8'h00;
   localparam logic        SEL_RESET      = 1'b0;
endpackage
`default_nettype wire

/* File: logic/rassw_uart_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// 8N1 receiver at the fixed command rate; bytes at other rates fail framing only when the stop-bit sample is low
module rassw_uart_rx #(
   parameter int unsigned BIT_CYC = rassw_pkg::BIT_CYC  // Clock cycles per bit
) (
   input  wire logic       mclk,     // System clock
   input  wire logic       rst_n,    // Sync reset, active low
   input  wire logic       rxd,      // Synchronised serial input
   output logic [7:0]      rx_data,  // Received byte
   output logic            rx_valid  // One-cycle pulse, good byte
);
   typedef enum logic [1:0] {IDLE, START, DATA, STOP} rassw_rx_type;
   rassw_rx_type           st_r;
   logic [15:0]            cnt_r;
   logic [2:0]             bit_r;
   logic [7:0]             sh_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r     <= IDLE;
         cnt_r    <= 16'h0000;
         bit_r    <= 3'h0;
         sh_r     <= 8'h00;
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         unique case (st_r)
            IDLE: begin
               if (!rxd) begin
                  st_r  <= START;
                  cnt_r <= 16'(BIT_CYC / 2);
               end
            end
            START: begin
               if (cnt_r == 16'h0000) begin
                  st_r  <= rxd ? IDLE : DATA;
                  cnt_r <= 16'(BIT_CYC - 1);
                  bit_r <= 3'h0;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            DATA: begin
               if (cnt_r == 16'h0000) begin
                  sh_r  <= {rxd, sh_r[7:1]};
                  cnt_r <= 16'(BIT_CYC - 1);
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     st_r <= STOP;
                  end
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
            STOP: begin
               if (cnt_r == 16'h0000) begin
                  // Framing check rejects most off-rate bytes
                  rx_valid <= rxd;
                  rx_data  <= sh_r;
                  st_r     <= IDLE;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: logic/rassw_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rassw_top #(
   parameter int unsigned BIT_CYC = rassw_pkg::BIT_CYC  // Clock cycles per command bit
) (
   input  wire logic       mclk,        // System clock, 250 MHz
   input  wire logic       rst_n,       // Sync reset, active low
   input  wire logic [7:0] addr_sw,     // Address switches, weighted binary
   input  wire logic       four_wire,   // Strap: 1 = four-wire, 0 = two-wire
   input  wire logic       bus_rx,      // RS485 receive data from host
   output logic            bus_tx,      // RS485 transmit data to host
   output logic            bus_tx_oe,   // RS485 driver enable
   input  wire logic       inst_rx,     // Instrument port data toward host
   output logic            inst_tx,     // Instrument port data from host
   output logic            selected     // Selected indicator
);
   logic                   rx_m_r;
   logic                   rx_s_r;
   logic [7:0]             rx_data;
   logic                   rx_valid;
   logic [7:0]             addr_m_r;
   logic [7:0]             my_addr_r;
   logic [3:0]             hi_r;
   logic [4:0]             nib;
   logic                   sel_r;

   typedef enum logic [1:0] {W_XOFF, W_HI, W_LO, W_SOH} rassw_cmd_type;
   rassw_cmd_type          cs_r;
   logic [3:0]             lo_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_m_r <= 1'b1;
         rx_s_r <= 1'b1;
      end else begin
         rx_m_r <= bus_rx;
         rx_s_r <= rx_m_r;
      end
   end

   always_ff @(posedge mclk) begin
      // Switches are a pin, so two flops
      if (!rst_n) begin
         addr_m_r  <= rassw_pkg::ADDR_DEFAULT;
         my_addr_r <= rassw_pkg::ADDR_DEFAULT;
      end else begin
         addr_m_r  <= addr_sw;
         my_addr_r <= addr_m_r;
      end
   end

   rassw_uart_rx #(
      .BIT_CYC  (BIT_CYC)
   ) rassw_uart_rx_i (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .rxd      (rx_s_r),
      .rx_data  (rx_data),
      .rx_valid (rx_valid)
   );

   // Hex digit decode, bit 4 flags invalid
   always_comb begin
      nib = 5'h10;
      if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
         nib = {1'b0, 4'(rx_data - 8'h30)};
      end else if (rx_data >= 8'h41 && rx_data <= 8'h46) begin
         nib = {1'b0, 4'(rx_data - 8'h37)};
      end else if (rx_data >= 8'h61 && rx_data <= 8'h66) begin
         nib = {1'b0, 4'(rx_data - 8'h57)};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cs_r <= W_XOFF;
         hi_r <= 4'h0;
         lo_r <= 4'h0;
      end else if (rx_valid) begin
         unique case (cs_r)
            W_XOFF: cs_r <= (rx_data == rassw_pkg::CHR_FLOW_OFF) ? W_HI : W_XOFF;
            W_HI: begin
               hi_r <= nib[3:0];
               cs_r <= nib[4] ? W_XOFF : W_LO;
               if (rx_data == rassw_pkg::CHR_FLOW_OFF) begin
                  cs_r <= W_HI;
               end
            end
            W_LO: begin
               lo_r <= nib[3:0];
               cs_r <= nib[4] ? W_XOFF : W_SOH;
               if (rx_data == rassw_pkg::CHR_FLOW_OFF) begin
                  cs_r <= W_HI;
               end
            end
            W_SOH: cs_r <= (rx_data == rassw_pkg::CHR_FLOW_OFF) ? W_HI : W_XOFF;
         endcase
      end
   end

   logic                   cmd_done;
   assign cmd_done = rx_valid && cs_r == W_SOH && rx_data == rassw_pkg::CHR_SOH;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_r <= rassw_pkg::SEL_RESET;
      end else if (cmd_done) begin
         sel_r <= ({hi_r, lo_r} == my_addr_r);
      end
   end

   assign selected = sel_r;

   assign inst_tx   = sel_r ? bus_rx : 1'b1;
   assign bus_tx    = sel_r ? inst_rx : 1'b1;
   assign bus_tx_oe = sel_r & (four_wire | ~inst_rx);


   property p_sel_on_match;
      @(posedge mclk) disable iff (!rst_n)
      cmd_done && {hi_r, lo_r} == my_addr_r |=> selected;
   endproperty
   property p_desel_other;
      @(posedge mclk) disable iff (!rst_n)
      cmd_done && {hi_r, lo_r} != my_addr_r |=> !selected;
   endproperty
   property p_sel_hold;
      @(posedge mclk) disable iff (!rst_n)
      !cmd_done |=> $stable(selected);
   endproperty
   property p_pass_fwd;
      @(posedge mclk) disable iff (!rst_n)
      selected |-> inst_tx == bus_rx;
   endproperty
   property p_pass_back;
      @(posedge mclk) disable iff (!rst_n)
      selected |-> bus_tx == inst_rx;
   endproperty
   property p_idle_mark;
      @(posedge mclk) disable iff (!rst_n)
      !selected |-> inst_tx && bus_tx && !bus_tx_oe;
   endproperty
   property p_oe_4w;
      @(posedge mclk) disable iff (!rst_n)
      selected && four_wire |-> bus_tx_oe;
   endproperty
   property p_oe_2w;
      @(posedge mclk) disable iff (!rst_n)
      selected && !four_wire |-> bus_tx_oe == !inst_rx;
   endproperty
   property p_cmd_order;
      @(posedge mclk) disable iff (!rst_n)
      cmd_done |-> $past(cs_r) == W_LO || $past(cs_r) == W_SOH;
   endproperty
   // Flow-off restarts wherever the sequencer stands
   property p_restart;
      @(posedge mclk) disable iff (!rst_n)
      rx_valid && rx_data == rassw_pkg::CHR_FLOW_OFF |=> cs_r == W_HI;
   endproperty
   property p_hi_bad;
      @(posedge mclk) disable iff (!rst_n)
      rx_valid && cs_r == W_HI && nib[4] && rx_data != rassw_pkg::CHR_FLOW_OFF
         |=> cs_r == W_XOFF;
   endproperty
   property p_lo_good;
      @(posedge mclk) disable iff (!rst_n)
      rx_valid && cs_r == W_LO && !nib[4] |=> cs_r == W_SOH;
   endproperty

   a_sel_on_match: assert property (p_sel_on_match)
      else $error("no select on match");
   a_desel_other: assert property (p_desel_other)
      else $error("no deselect");
   a_sel_hold: assert property (p_sel_hold)
      else $error("select changed without command");
   a_pass_fwd: assert property (p_pass_fwd)
      else $error("forward path wrong");
   a_pass_back: assert property (p_pass_back)
      else $error("return path wrong");
   a_idle_mark: assert property (p_idle_mark)
      else $error("idle lines not marking");
   a_oe_4w: assert property (p_oe_4w)
      else $error("four-wire enable wrong");
   a_oe_2w: assert property (p_oe_2w)
      else $error("two-wire enable wrong");
   a_cmd_order: assert property (p_cmd_order)
      else $error("command out of order");
   a_restart: assert property (p_restart)
      else $error("flow-off did not restart command");
   a_hi_bad: assert property (p_hi_bad)
      else $error("bad upper character not refused");
   a_lo_good: assert property (p_lo_good)
      else $error("good lower character not taken");

   c_select: cover property (@(posedge mclk) disable iff (!rst_n) $rose(selected));
   c_deselect: cover property (@(posedge mclk) disable iff (!rst_n) $fell(selected));
   c_fwd: cover property (@(posedge mclk) disable iff (!rst_n) selected && $fell(inst_tx));
   c_four_wire: cover property (@(posedge mclk) disable iff (!rst_n)
      selected && four_wire && bus_tx_oe);
   c_two_wire: cover property (@(posedge mclk) disable iff (!rst_n)
      selected && !four_wire && bus_tx_oe);
endmodule
`default_nettype wire

/* File: testbench/rassw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host on the multi-drop bus; line rests at mark between frames
module rassw_host_model (
   input  wire logic mclk,  // System clock
   output logic      txd    // Serial line toward the switch
);
   initial txd = 1'b1;
   task automatic level(input logic v);
      @(posedge mclk) #1;
      txd = v;
   endtask
   task automatic send_byte(input logic [7:0] b, input int bit_cyc);
      logic [9:0] frm;
      frm = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         level(frm[i]);
         repeat (bit_cyc - 1) @(posedge mclk);
      end
   endtask
   function automatic logic [7:0] hex(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   task automatic select(input logic [7:0] a, input int bit_cyc);
      send_byte(8'h13, bit_cyc);
      send_byte(hex(a[7:4]), bit_cyc);
      send_byte(hex(a[3:0]), bit_cyc);
      send_byte(8'h01, bit_cyc);
   endtask
endmodule
`default_nettype wire

/* File: testbench/rassw_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rassw_top_tb;
   localparam int LIMIT = 20_000;
   // Scaled bit time keeps the run short; real rate is the package default
   localparam int BC    = 64;
   logic       mclk, rst_n, four_wire, bus_rx, bus_tx, bus_tx_oe, inst_rx, inst_tx, selected;
   logic [7:0] addr_sw;
   int         mismatches, n_tests, cyc;
   rassw_top #(.BIT_CYC(BC)) rassw_top_i (.mclk(mclk), .rst_n(rst_n), .addr_sw(addr_sw),
      .four_wire(four_wire), .bus_rx(bus_rx), .bus_tx(bus_tx), .bus_tx_oe(bus_tx_oe),
      .inst_rx(inst_rx), .inst_tx(inst_tx), .selected(selected));
   // Single device, so its address is unique
   rassw_host_model rassw_host_model_i (.mclk(mclk), .txd(bus_rx));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Ceiling covers four scaled commands, the waits and slack
   always @(posedge mclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         summarize();
      end
   end
   task automatic t_reset();
      chk(selected, 1'b0);
      chk(inst_tx, 1'b1);
      chk(bus_tx, 1'b1);
      chk(bus_tx_oe, 1'b0);
   endtask
   task automatic t_select();
      addr_sw = 8'h8f;
      rassw_host_model_i.select(8'h8f, BC);
      repeat (8) @(posedge mclk);
      chk(selected, 1'b1);
   endtask
   // Low pulses stay far shorter than half a bit, so no false byte
   task automatic t_pass();
      rassw_host_model_i.level(1'b0);
      #1;
      chk(inst_tx, 1'b0);
      @(posedge mclk) #1;
      inst_rx = 1'b0;
      #1;
      chk(bus_tx, 1'b0);
      chk(bus_tx_oe, 1'b1);
      @(posedge mclk) #1;
      inst_rx = 1'b1;
      #1;
      chk(bus_tx_oe, 1'b0);
      @(posedge mclk) #1;
      four_wire = 1'b1;
      #1;
      chk(bus_tx_oe, 1'b1);
      chk(bus_tx, 1'b1);
      @(posedge mclk) #1;
      four_wire = 1'b0;
      rassw_host_model_i.level(1'b1);
      #1;
      chk(inst_tx, 1'b1);
   endtask
   task automatic t_other_rate();
      rassw_host_model_i.select(8'h00, BC / 2);
      repeat (10 * BC) @(posedge mclk);
      #1;
      chk(selected, 1'b1);
   endtask
   task automatic t_deselect();
      rassw_host_model_i.select(8'h12, BC);
      repeat (8) @(posedge mclk);
      #1;
      chk(selected, 1'b0);
      rassw_host_model_i.level(1'b0);
      #1;
      chk(inst_tx, 1'b1);
      rassw_host_model_i.level(1'b1);
   endtask
   task automatic t_default();
      @(posedge mclk) #1;
      addr_sw = 8'h00;
      rassw_host_model_i.select(8'h00, BC);
      repeat (8) @(posedge mclk);
      #1;
      chk(selected, 1'b1);
   endtask
   task automatic t_mid_reset();
      @(posedge mclk) #1;
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      chk(selected, 1'b0);
      chk(bus_tx_oe, 1'b0);
      chk(inst_tx, 1'b1);
   endtask
   initial begin
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      rst_n = 1'b0;
      addr_sw = 8'h00;
      four_wire = 1'b0;
      inst_rx = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_select();
      t_pass();
      t_other_rate();
      t_deselect();
      t_default();
      t_mid_reset();
      summarize();
   end
endmodule
`default_nettype wire
